//--- design/p1fs_pkg.sv
// constants and types for the port-1 pin function select block
`default_nettype none

package p1fs_pkg;

  // ********************************
  // geometry
  // ********************************
  localparam int P1FS_NUM_PINS = 8;
  localparam int P1FS_ADDR_W = 8;

  // ********************************
  // register byte offsets
  // ********************************
  localparam logic [7:0] P1FS_OFS_SEL = 8'h00;
  localparam logic [7:0] P1FS_OFS_DIR = 8'h04;
  localparam logic [7:0] P1FS_OFS_PU = 8'h08;
  localparam logic [7:0] P1FS_OFS_DATA = 8'h0c;
  localparam logic [7:0] P1FS_OFS_STAT = 8'h10;

  // ********************************
  // reset values and fixed read values
  // ********************************
  localparam logic [7:0] P1FS_RST_SEL = 8'h00;
  localparam logic [7:0] P1FS_RST_DIR = 8'h00;
  localparam logic [7:0] P1FS_RST_PU = 8'h00;
  localparam logic [7:0] P1FS_RST_DATA = 8'h00;
  localparam logic [7:0] P1FS_RST_OE_N = 8'hff;
  localparam logic [31:0] P1FS_DIR_READ = 32'h0000_00ff;

  // ********************************
  // pin positions of shared functions
  // ********************************
  localparam int P1FS_PIN_INT_C = 7;
  localparam int P1FS_PIN_INT_B = 6;
  localparam int P1FS_PIN_INT_A = 5;
  localparam int P1FS_PIN_INT_D = 4;
  localparam int P1FS_PIN_TMR_G = 3;
  localparam int P1FS_PIN_TF_HI = 2;
  localparam int P1FS_PIN_TF_LO = 1;
  localparam int P1FS_PIN_WCLK = 0;
  localparam int P1FS_NUM_OUT_FN = 3;

  // ********************************
  // clock-source patterns
  // ********************************
  localparam int P1FS_TF_SRC_MSB = 2;
  localparam logic [2:0] P1FS_TC_EVT_SRC = 3'h7;

  // ********************************
  // bus answers
  // ********************************
  localparam logic [1:0] P1FS_RESP_OKAY = 2'h0;
  localparam logic [1:0] P1FS_RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    P1FS_ACTIVE,
    P1FS_SUBACTIVE,
    P1FS_SLEEP,
    P1FS_SUBSLEEP,
    P1FS_WATCH,
    P1FS_STANDBY
  } p1fs_mode_t;

endpackage : p1fs_pkg

`default_nettype wire

//--- design/p1fs_top.sv
// port-1 pin function select, pull-up control and axi4-lite register slave
//
// The implementer's own choices: register access over AXI4-Lite and the placing of the registers.
`default_nettype none

// How it works
// - pin 7 select clear: direction bit picks general input or output
// - pin 7 select set: interrupt-c input; timer F event when source is 0xx
// - pin 6: direction bit when select clear, interrupt-b input when set
// - pin 5 select set: interrupt-a input; timer C event when source 111
// - pin 4 select set: interrupt-d input; adc trigger when trigger enable set
// - pins 3..0: timer G in, timer F compares, watch clock out, else general
// - pins floating in reset, held in sleep modes, live in active modes
// - standby floats every pin; a pin with pull-up on still reads high
// - pull-up on only when direction bit is 0 and pull-up bit is 1
// - all pull-ups off after reset
// - direction register write-only, reads all ones, resets to zero
module p1fs_top #(
  parameter int NUM_PINS = p1fs_pkg::P1FS_NUM_PINS,
  parameter int ADDR_W = p1fs_pkg::P1FS_ADDR_W
) (
  input wire logic clk_sys, // system clock
  input wire logic rstn, // synchronous reset, active low
  input wire logic [ADDR_W-1:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write byte strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [ADDR_W-1:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic [2:0] op_mode, // operating mode code
  input wire logic [NUM_PINS-1:0] pin_in, // pin levels
  output logic [NUM_PINS-1:0] pin_out, // pin drive level
  output logic [NUM_PINS-1:0] pin_oe_n, // pin drive enable, low drives
  output logic [NUM_PINS-1:0] pin_pullup_on, // input pull-up enable per pin
  input wire logic [2:0] timer_f_clock_source_field, // timer F clock source
  input wire logic [2:0] timer_c_clock_source_field, // timer C clock source
  input wire logic adc_trigger_enable, // adc external trigger enable
  input wire logic tf_high_compare_out, // timer F high compare output
  input wire logic tf_low_compare_out, // timer F low compare output
  input wire logic watch_clock_out, // watch clock output
  output logic ext_int_a, // interrupt-a input, idle high
  output logic ext_int_b, // interrupt-b input, idle high
  output logic ext_int_c, // interrupt-c input, idle high
  output logic ext_int_d, // interrupt-d input, idle high
  output logic timer_f_event_input, // timer F event, idle high
  output logic timer_c_event_input, // timer C event, idle high
  output logic adc_external_trigger, // adc trigger, idle high
  output logic timer_g_input // timer G input, idle high
);

  // ********************************
  // elaboration checks
  // ********************************
  if (NUM_PINS != 8) begin : g_chk_pins
    $error("p1fs_top serves exactly eight pins");
  end
  if (ADDR_W < 8) begin : g_chk_addr
    $error("p1fs_top needs at least eight address bits");
  end

  // ********************************
  // state
  // ********************************
  typedef struct packed {
    logic [7:0] sel;
    logic [7:0] dir;
    logic [7:0] pu;
    logic [7:0] data;
    logic [7:0] drv;
    logic [7:0] oe_n;
    logic aw_got;
    logic w_got;
    logic [ADDR_W-1:0] aw_addr;
    logic [7:0] w_data;
    logic w_strb0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } p1fs_state_t;

  p1fs_state_t s_r;
  p1fs_state_t s_nxt;
  p1fs_pkg::p1fs_mode_t mode;
  logic [7:0] func_oe_n;
  logic [7:0] func_out;
  logic [7:0] pin_rd;
  logic [7:0] periph_out;
  logic wr_do;
  logic rd_do;
  logic run;
  logic hold;

  assign mode = p1fs_pkg::p1fs_mode_t'(op_mode);
  assign periph_out = {5'h00, tf_high_compare_out, tf_low_compare_out, watch_clock_out};
  assign rd_do = s_axi_arvalid && s_axi_arready;

  // ********************************
  // pin function routing
  // ********************************
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (s_r.sel[i] && i < p1fs_pkg::P1FS_NUM_OUT_FN) begin
        func_oe_n[i] = 1'b0;
        func_out[i] = periph_out[i];
      end else if (s_r.sel[i]) begin
        func_oe_n[i] = 1'b1;
        func_out[i] = s_r.data[i];
      end else begin
        func_oe_n[i] = ~s_r.dir[i];
        func_out[i] = s_r.data[i];
      end
      pin_rd[i] = (!s_r.sel[i] && s_r.dir[i]) ? s_r.data[i] : pin_in[i];
    end
  end

  // shared peripheral inputs, idle high when not routed
  assign ext_int_c = s_r.sel[p1fs_pkg::P1FS_PIN_INT_C] ? pin_in[p1fs_pkg::P1FS_PIN_INT_C]
                     : 1'b1;
  assign timer_f_event_input = (s_r.sel[p1fs_pkg::P1FS_PIN_INT_C]
      && !timer_f_clock_source_field[p1fs_pkg::P1FS_TF_SRC_MSB])
      ? pin_in[p1fs_pkg::P1FS_PIN_INT_C] : 1'b1;
  assign ext_int_b = s_r.sel[p1fs_pkg::P1FS_PIN_INT_B] ? pin_in[p1fs_pkg::P1FS_PIN_INT_B]
                     : 1'b1;
  assign ext_int_a = s_r.sel[p1fs_pkg::P1FS_PIN_INT_A] ? pin_in[p1fs_pkg::P1FS_PIN_INT_A]
                     : 1'b1;
  assign timer_c_event_input = (s_r.sel[p1fs_pkg::P1FS_PIN_INT_A]
      && timer_c_clock_source_field == p1fs_pkg::P1FS_TC_EVT_SRC)
      ? pin_in[p1fs_pkg::P1FS_PIN_INT_A] : 1'b1;
  assign ext_int_d = s_r.sel[p1fs_pkg::P1FS_PIN_INT_D] ? pin_in[p1fs_pkg::P1FS_PIN_INT_D]
                     : 1'b1;
  assign adc_external_trigger = (s_r.sel[p1fs_pkg::P1FS_PIN_INT_D] && adc_trigger_enable)
      ? pin_in[p1fs_pkg::P1FS_PIN_INT_D] : 1'b1;
  assign timer_g_input = s_r.sel[p1fs_pkg::P1FS_PIN_TMR_G]
      ? pin_in[p1fs_pkg::P1FS_PIN_TMR_G] : 1'b1;

  assign pin_pullup_on = ~s_r.dir & s_r.pu;
  assign pin_out = s_r.drv;
  assign pin_oe_n = s_r.oe_n;

  // ********************************
  // bus handshakes
  // ********************************
  assign s_axi_awready = !s_r.aw_got && !s_r.bvalid;
  assign s_axi_wready = !s_r.w_got && !s_r.bvalid;
  assign s_axi_arready = !s_r.rvalid;
  assign s_axi_bvalid = s_r.bvalid;
  assign s_axi_bresp = s_r.bresp;
  assign s_axi_rvalid = s_r.rvalid;
  assign s_axi_rdata = s_r.rdata;
  assign s_axi_rresp = s_r.rresp;

  // ********************************
  // next state
  // ********************************
  always_comb begin
    s_nxt = s_r;
    wr_do = 1'b0;
    run = 1'b0;
    hold = 1'b0;
    // write channel capture, either order
    if (s_axi_awvalid && s_axi_awready) begin
      s_nxt.aw_got = 1'b1;
      s_nxt.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_nxt.w_got = 1'b1;
      s_nxt.w_data = s_axi_wdata[7:0];
      s_nxt.w_strb0 = s_axi_wstrb[0];
    end
    if (s_r.bvalid && s_axi_bready) begin
      s_nxt.bvalid = 1'b0;
    end
    if (s_nxt.aw_got && s_nxt.w_got) begin
      wr_do = 1'b1;
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = p1fs_pkg::P1FS_RESP_OKAY;
      case (s_nxt.aw_addr)
        ADDR_W'(p1fs_pkg::P1FS_OFS_SEL): begin
          if (s_nxt.w_strb0) s_nxt.sel = s_nxt.w_data;
        end
        ADDR_W'(p1fs_pkg::P1FS_OFS_DIR): begin
          if (s_nxt.w_strb0) s_nxt.dir = s_nxt.w_data;
        end
        ADDR_W'(p1fs_pkg::P1FS_OFS_PU): begin
          if (s_nxt.w_strb0) s_nxt.pu = s_nxt.w_data;
        end
        ADDR_W'(p1fs_pkg::P1FS_OFS_DATA): begin
          if (s_nxt.w_strb0) s_nxt.data = s_nxt.w_data;
        end
        ADDR_W'(p1fs_pkg::P1FS_OFS_STAT): begin
          s_nxt.bresp = p1fs_pkg::P1FS_RESP_OKAY;
        end
        default: begin
          s_nxt.bresp = p1fs_pkg::P1FS_RESP_SLVERR;
        end
      endcase
    end
    // read channel
    if (s_r.rvalid && s_axi_rready) begin
      s_nxt.rvalid = 1'b0;
    end
    if (rd_do) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp = p1fs_pkg::P1FS_RESP_OKAY;
      case (s_axi_araddr)
        ADDR_W'(p1fs_pkg::P1FS_OFS_SEL): s_nxt.rdata = {24'h00_0000, s_r.sel};
        ADDR_W'(p1fs_pkg::P1FS_OFS_DIR): s_nxt.rdata = p1fs_pkg::P1FS_DIR_READ;
        ADDR_W'(p1fs_pkg::P1FS_OFS_PU): s_nxt.rdata = {24'h00_0000, s_r.pu};
        ADDR_W'(p1fs_pkg::P1FS_OFS_DATA): s_nxt.rdata = {24'h00_0000, pin_rd};
        ADDR_W'(p1fs_pkg::P1FS_OFS_STAT): begin
          s_nxt.rdata = {16'h0000, pin_pullup_on, s_r.oe_n};
        end
        default: begin
          s_nxt.rdata = 32'h0000_0000;
          s_nxt.rresp = p1fs_pkg::P1FS_RESP_SLVERR;
        end
      endcase
    end
    // pin drive per operating mode
    case (mode)
      p1fs_pkg::P1FS_ACTIVE, p1fs_pkg::P1FS_SUBACTIVE: begin
        run = 1'b1;
        s_nxt.oe_n = func_oe_n;
        s_nxt.drv = func_out;
      end
      p1fs_pkg::P1FS_SLEEP, p1fs_pkg::P1FS_SUBSLEEP, p1fs_pkg::P1FS_WATCH: begin
        hold = 1'b1;
      end
      p1fs_pkg::P1FS_STANDBY: begin
        s_nxt.oe_n = p1fs_pkg::P1FS_RST_OE_N;
      end
      default: begin
        s_nxt.oe_n = p1fs_pkg::P1FS_RST_OE_N;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      s_r <= '0;
      s_r.sel <= p1fs_pkg::P1FS_RST_SEL;
      s_r.dir <= p1fs_pkg::P1FS_RST_DIR;
      s_r.pu <= p1fs_pkg::P1FS_RST_PU;
      s_r.data <= p1fs_pkg::P1FS_RST_DATA;
      s_r.oe_n <= p1fs_pkg::P1FS_RST_OE_N;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ********************************
  // assertions
  // ********************************
  default clocking cb_sys @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  property p_p7_io;
    run && !s_r.sel[7] |=> pin_oe_n[7] == !$past(s_r.dir[7]);
  endproperty
  a_p7_io: assert property (p_p7_io) else $error("pin 7 general direction wrong");

  property p_p7_irq;
    s_r.sel[7] |-> ext_int_c == pin_in[7] && timer_f_event_input ==
      (timer_f_clock_source_field[2] ? 1'b1 : pin_in[7]);
  endproperty
  a_p7_irq: assert property (p_p7_irq) else $error("pin 7 shared input wrong");

  property p_p6_irq;
    run && s_r.sel[6] |-> ext_int_b == pin_in[6] ##1 pin_oe_n[6];
  endproperty
  a_p6_irq: assert property (p_p6_irq) else $error("pin 6 not interrupt-b input");

  property p_p5_tc;
    s_r.sel[5] && timer_c_clock_source_field == 3'h7 |-> timer_c_event_input == pin_in[5];
  endproperty
  a_p5_tc: assert property (p_p5_tc) else $error("pin 5 timer C event wrong");

  property p_p4_adc;
    !s_r.sel[4] || !adc_trigger_enable |-> adc_external_trigger;
  endproperty
  a_p4_adc: assert property (p_p4_adc) else $error("adc trigger leaked");

  property p_p2_out;
    run && s_r.sel[2] |=> !pin_oe_n[2] && pin_out[2] == $past(tf_high_compare_out);
  endproperty
  a_p2_out: assert property (p_p2_out) else $error("pin 2 compare output wrong");

  property p_hold;
    hold |=> $stable(pin_oe_n) && $stable(pin_out);
  endproperty
  a_hold: assert property (p_hold) else $error("pins moved in sleep mode");

  property p_standby;
    mode == p1fs_pkg::P1FS_STANDBY |=> pin_oe_n == 8'hff;
  endproperty
  a_standby: assert property (p_standby) else $error("pin driven in standby");

  property p_pu;
    (pin_pullup_on & s_r.dir) == 8'h00;
  endproperty
  a_pu: assert property (p_pu) else $error("pull-up on an output pin");

  property p_pu_rst;
    $rose(rstn) |-> pin_pullup_on == 8'h00 && pin_oe_n == 8'hff;
  endproperty
  a_pu_rst: assert property (p_pu_rst) else $error("pull-up or drive after reset");

  property p_dir_rd;
    rd_do && s_axi_araddr == ADDR_W'(8'h04) |=> s_axi_rvalid && s_axi_rdata == 32'h0000_00ff;
  endproperty
  a_dir_rd: assert property (p_dir_rd) else $error("direction read not all ones");

  property p_upd;
    wr_do && s_nxt.aw_addr == ADDR_W'(8'h00) && s_nxt.w_strb0
      |=> s_r.sel == $past(s_nxt.w_data);
  endproperty
  a_upd: assert property (p_upd) else $error("select write not applied");

  c_write: cover property (wr_do ##1 s_axi_bvalid && s_axi_bready);
  c_read: cover property (rd_do ##1 s_axi_rvalid && s_axi_rready);
  c_p7_tmr: cover property (s_r.sel[7] && !timer_f_clock_source_field[2]);
  c_standby: cover property (mode == p1fs_pkg::P1FS_STANDBY && pin_pullup_on != 8'h00);

endmodule : p1fs_top

`default_nettype wire

//--- testbench/p1fs_ext_model.sv
// model of the circuitry wired to the eight port pins
`default_nettype none
module p1fs_ext_model (
  input wire logic clk_sys, // system clock
  input wire logic [7:0] pin_out, // design drive level
  input wire logic [7:0] pin_oe_n, // design drive enable, low drives
  input wire logic [7:0] pin_pullup_on, // design pull-up per pin
  input wire logic [7:0] ext_en, // outside driver on
  input wire logic [7:0] ext_val, // outside driver level
  output logic [7:0] pin_in // resolved pin level
);
  timeunit 1ns;
  timeprecision 1ps;
  logic tgl = 1'b0;
  always @(posedge clk_sys) tgl <= ~tgl;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (!pin_oe_n[i]) pin_in[i] = pin_out[i];
      else if (ext_en[i]) pin_in[i] = ext_val[i];
      else if (pin_pullup_on[i]) pin_in[i] = 1'b1;
      else pin_in[i] = tgl ^ i[0]; // floating pin never holds a level
    end
  end
endmodule : p1fs_ext_model
`default_nettype wire

//--- testbench/p1fs_top_test.sv
// self-checking bench for the port-1 pin function select block
`default_nettype none
module p1fs_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // signals
  // ****
  localparam logic [7:0] A_SEL = p1fs_pkg::P1FS_OFS_SEL;
  localparam logic [7:0] A_DIR = p1fs_pkg::P1FS_OFS_DIR;
  localparam logic [7:0] A_PU = p1fs_pkg::P1FS_OFS_PU;
  localparam logic [7:0] A_DAT = p1fs_pkg::P1FS_OFS_DATA;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [2:0] op_mode = 3'h0;
  logic [2:0] tf_src = 3'h3, tc_src = 3'h7;
  logic adc_en = 1'b1, cmp_hi = 1'b0, cmp_lo = 1'b0, wclk = 1'b0;
  logic [7:0] ext_en = 8'h00, ext_val = 8'h00;
  logic [3:0] wstrb = 4'hf;
  logic [2:0] int_en = 3'h7; // software interrupt enables c, a, d
  int irq_seen = 0;
  logic [7:0] pin_in, pin_out, pin_oe_n, pu_on;
  logic ia, ib, ic, id, tfe, tce, adt, tg;
  int fail_count = 0;
  int num_checks = 0;
  p1fs_pkg::p1fs_mode_t fz[3] = '{p1fs_pkg::P1FS_SLEEP, p1fs_pkg::P1FS_SUBSLEEP,
    p1fs_pkg::P1FS_WATCH};
  always #5 clk_sys = ~clk_sys;
  p1fs_top dut_u (
    .clk_sys, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(wstrb), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready(1'b1), .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready(1'b1), .op_mode, .pin_in, .pin_out,
    .pin_oe_n, .pin_pullup_on(pu_on), .timer_f_clock_source_field(tf_src),
    .timer_c_clock_source_field(tc_src), .adc_trigger_enable(adc_en),
    .tf_high_compare_out(cmp_hi), .tf_low_compare_out(cmp_lo), .watch_clock_out(wclk),
    .ext_int_a(ia), .ext_int_b(ib), .ext_int_c(ic), .ext_int_d(id),
    .timer_f_event_input(tfe), .timer_c_event_input(tce), .adc_external_trigger(adt),
    .timer_g_input(tg)
  );
  p1fs_ext_model ext_u (.clk_sys, .pin_out, .pin_oe_n, .pin_pullup_on(pu_on), .ext_en,
    .ext_val, .pin_in);
  // enabled active-low interrupt level seen by the software model
  always @(posedge clk_sys) begin
    if ((int_en & ~{ic, ia, id}) != 3'h0) irq_seen <= irq_seen + 1;
  end
  // ****
  // tasks
  // ****
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : test_done
  task automatic chkb(input string w, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", w, e, g);
    end
  endtask : chkb
  task automatic chkp(input string w, input logic [7:0] e, input logic [7:0] g);
    chkb(w, {24'h0, e}, {24'h0, g});
  endtask : chkp
  task automatic hang();
    fail_count++;
    $display("ERROR bus answer expected within 50 cycles seen none");
    test_done();
  endtask : hang
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : step
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    int n;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    if (n == 50) hang();
    chkb("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    int n;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    if (n == 50) hang();
    chkb("rdata", e, s_axi_rdata);
    chkb("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
  endtask : rd
  // ****
  // sequence
  // ****
  initial begin
    step(2);
    chkp("oe_n in reset", 8'hff, pin_oe_n);
    step(2);
    rstn <= 1'b1;
    step(1);
    chkp("pullup", 8'h00, pu_on);
    rd(A_DIR, 32'hff, 2'h0);
    rd(A_SEL, 32'h0, 2'h0);
    rd(A_PU, 32'h0, 2'h0);
    $display("test reset done");
    wr(A_PU, 8'hff, 2'h0);
    wr(A_DIR, 8'h0f, 2'h0);
    chkp("pullup", 8'hf0, pu_on);
    rd(p1fs_pkg::P1FS_OFS_STAT, 32'hf0f0, 2'h0);
    rd(A_DIR, 32'hff, 2'h0);
    rd(A_PU, 32'hff, 2'h0);
    $display("test pullup done");
    ext_en <= 8'hf0;
    wr(A_DAT, 8'ha5, 2'h0);
    step(2);
    chkp("pin_out", 8'h05, pin_out & 8'h0f);
    chkp("oe_n", 8'hf0, pin_oe_n);
    chkp("fn in", 8'hff, {ic, ib, ia, id, tg, tfe, tce, adt});
    rd(A_DAT, 32'h05, 2'h0);
    $display("test general io done");
    int_en <= 3'h0;
    ext_en <= 8'hf8;
    wr(A_SEL, 8'hff, 2'h0);
    rd(A_SEL, 32'hff, 2'h0);
    for (int v = 0; v < 2; v++) begin
      ext_val <= v[0] ? 8'hff : 8'h00;
      cmp_hi <= v[0];
      cmp_lo <= !v[0];
      wclk <= v[0];
      step(2);
      chkp("oe_n", 8'hf8, pin_oe_n);
      chkp("out fn", {5'h0, v[0], !v[0], v[0]}, pin_out & 8'h07);
      chkp("fn in", {8{v[0]}}, {ic, ib, ia, id, tg, tfe, tce, adt});
    end
    ext_val <= 8'h00;
    for (int s = 0; s < 8; s++) begin
      tf_src <= s[2:0];
      tc_src <= s[2:0];
      adc_en <= s[0];
      step(2);
      chkp("evt", {5'h0, s[2], s != 7, !s[0]}, {5'h0, tfe, tce, adt});
    end
    chkb("irq raised", 32'h0, irq_seen);
    $display("test shared functions done");
    wr(A_SEL, 8'h00, 2'h0);
    wr(A_DAT, 8'h0f, 2'h0);
    for (int m = 0; m < 3; m++) begin
      op_mode <= fz[m];
      wr(A_DAT, 8'h00, 2'h0);
      step(2);
      chkp("held out", 8'h0f, pin_out & 8'h0f);
      op_mode <= p1fs_pkg::P1FS_SUBACTIVE;
      step(2);
      chkp("live out", 8'h00, pin_out & 8'h0f);
      wr(A_DAT, 8'h0f, 2'h0);
    end
    ext_en <= 8'h00;
    op_mode <= p1fs_pkg::P1FS_STANDBY;
    step(2);
    chkp("oe_n", 8'hff, pin_oe_n);
    chkp("pullup", 8'hf0, pu_on);
    chkp("standby high", 8'hf0, pin_in & 8'hf0);
    op_mode <= p1fs_pkg::P1FS_ACTIVE;
    step(2);
    chkp("oe_n", 8'hf0, pin_oe_n);
    op_mode <= 3'h6;
    step(2);
    chkp("oe_n", 8'hff, pin_oe_n);
    op_mode <= p1fs_pkg::P1FS_ACTIVE;
    $display("test modes done");
    wr(8'h20, 8'h55, p1fs_pkg::P1FS_RESP_SLVERR);
    rd(8'h20, 32'h0, p1fs_pkg::P1FS_RESP_SLVERR);
    wstrb <= 4'he;
    wr(A_PU, 8'h00, 2'h0);
    wstrb <= 4'hf;
    rd(A_PU, 32'hff, 2'h0);
    $display("test unmapped done");
    test_done();
  end
endmodule : p1fs_top_test
`default_nettype wire
